// ---- icr_consts.svh ----
`ifndef ICR_CONSTS_SVH
`define ICR_CONSTS_SVH
// Framing
`define FLAG_BYTE   8'h7E
`define CRC_POLY    8'h07
`define CRC_INIT    8'h00
`define BODY_LAST   3'h5
`define TX_LAST     3'h7
// Message object numbers
`define OBJ_STATUS  4'h0
`define OBJ_SYSCFG  4'h1
`define OBJ_GETPAR  4'h6
`define OBJ_SETPAR  4'h7
// Status selectors and fill
`define SEL_STATE   8'h00
`define SEL_LOAD    8'h01
`define FILL_BYTE   8'hFF
// Object 1 command words
`define CMD_UNLOCK  16'h0000
`define CMD_RESET   16'h0001
`define CMD_STATIC  16'h0002
`define CMD_BOOT    16'h00BD
`define CMD_BAUD    16'h0100
`define CMD_COH_EN  16'h0200
`define CMD_COH_DIS 16'h0201
`define CMD_COH_SET 16'h0202
`define CMD_FLOAD   16'h0300
`define CMD_FSAVE   16'h0301
`define CMD_FERASE  16'h0302
`define VAL_OFF     16'h0000
`define VAL_ON      16'h0001
`define BOOT_CFG    16'h32CD
`define BOOT_LDR    16'hA25D
`define UNLOCK_MAX  16'h0002
// Baud word is bps/100; default 1 Mbps
`define BAUD_DEF    16'h2710
`define ERR_LIMIT   3'h3
`define STATIC_APP  8'h00
// AXI4-Lite register map
`define AXI_AW      6
`define REG_CTRL    6'h00
`define REG_STAT    6'h04
`define REG_BAUD    6'h08
`define REG_SEQ     6'h0C
`define REG_FILE    6'h10
`define REG_CNT     6'h14
`define RESP_OKAY   2'h0
`define RESP_DECERR 2'h3
`define FILE_PEND   31
`endif

// ---- icr_pkg.sv ----
package icr_pkg;
	// Link frame fields between the flags, check byte excluded
	typedef struct packed {
		logic [1:0] seq;
		logic [1:0] res;
		logic [3:0] obj;
		logic [7:0] d0;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [7:0] d3;
	} icr_frame_t;
	// Live status sampled for object 0 replies
	typedef struct packed {
		logic [7:0]  motor_state_number;
		logic [7:0]  power_factor_state_number;
		logic [15:0] exe_time;
		logic [15:0] cpu_load;
	} icr_status_t;
	typedef enum logic [4:0] {
		ST_HUNT = 5'b00001,
		ST_BODY = 5'b00010,
		ST_TAIL = 5'b00100,
		ST_EXEC = 5'b01000,
		ST_SEND = 5'b10000
	} icr_state_t;
	typedef enum logic [2:0] {
		MODE_APP  = 3'b001,
		MODE_CFG  = 3'b010,
		MODE_BOOT = 3'b100
	} icr_mode_t;
endpackage

// ---- icr_responder.sv ----
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "icr_consts.svh"
module icr_responder import icr_pkg::*; #(
	parameter int APP_W = 2, // Function group id bits kept
	parameter int IDX_W = 4  // Parameter index bits kept
) (
	input  wire logic              CLK,           // System clock
	input  wire logic              RST_N,         // Sync reset, low
	input  wire logic              RX_VALID,      // Received byte strobe
	input  wire logic [7:0]        RX_BYTE,       // Received byte
	input  wire logic              RX_FRAME_ERR,  // Framing error pulse
	input  wire logic              TX_READY,      // Transmitter takes byte
	output logic                   TX_VALID,      // Byte offered
	output logic [7:0]             TX_BYTE,       // Byte to send
	input  wire icr_status_t       STATUS_IN,     // Live status words
	output logic [15:0]            BAUD_DIV,      // Baud word, bps/100
	output icr_mode_t              BOOT_MODE,     // Selected boot mode
	output logic                   STATIC_WR_EN,  // Static writes allowed
	output logic                   COHERENT_EN,   // Coherent handling on
	output logic                   COH_APPLY,     // Apply pulse
	output logic                   RESET_REQ,     // Self reset pulse
	input  wire logic [`AXI_AW-1:0] S_AXI_AWADDR, // Write address
	input  wire logic              S_AXI_AWVALID, // Write address valid
	output logic                   S_AXI_AWREADY, // Write address ready
	input  wire logic [31:0]       S_AXI_WDATA,   // Write data
	input  wire logic [3:0]        S_AXI_WSTRB,   // Byte enables
	input  wire logic              S_AXI_WVALID,  // Write data valid
	output logic                   S_AXI_WREADY,  // Write data ready
	output logic [1:0]             S_AXI_BRESP,   // Write response
	output logic                   S_AXI_BVALID,  // Write response valid
	input  wire logic              S_AXI_BREADY,  // Write response ready
	input  wire logic [`AXI_AW-1:0] S_AXI_ARADDR, // Read address
	input  wire logic              S_AXI_ARVALID, // Read address valid
	output logic                   S_AXI_ARREADY, // Read address ready
	output logic [31:0]            S_AXI_RDATA,   // Read data
	output logic [1:0]             S_AXI_RRESP,   // Read response
	output logic                   S_AXI_RVALID,  // Read data valid
	input  wire logic              S_AXI_RREADY   // Read data ready
);
	localparam int PAR_N = 1 << (APP_W + IDX_W);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] crc8(input logic [39:0] msg);
		logic [7:0] c;
		c = `CRC_INIT;
		for (int i = 39; i >= 0; i--) begin
			c = (c[7] ^ msg[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic reg_known(input logic [`AXI_AW-1:0] a);
		return a == `REG_CTRL || a == `REG_STAT || a == `REG_BAUD ||
			a == `REG_SEQ || a == `REG_FILE || a == `REG_CNT;
	endfunction

	// ==========================================================
	// State
	icr_state_t       st_q;              // Link sequencer
	logic [2:0]       cnt_q;             // Byte counter
	logic [47:0]      body_q;            // Header, data, check
	logic [55:0]      tx_buf_q;          // Bytes still to send
	logic [1:0]       seq_q;             // Expected command seq
	logic [1:0]       tx_seq_q;          // Response seq
	logic [1:0]       unlock_q;          // Unprotect allowance
	logic [2:0]       err_q;             // Framing error count
	logic [15:0]      file_arg_q;        // File command value
	logic [1:0]       file_op_q;         // File command code
	logic             file_pend_q;       // File request pending
	logic [15:0]      ok_cnt_q;          // Accepted frames
	logic [15:0]      drop_cnt_q;        // Discarded frames
	logic             link_en_q;         // Software link enable
	logic [15:0]      par_q [PAR_N];     // Parameter store
	logic             rst_int;           // Power or self reset
	// Exec decode
	icr_frame_t       fr;                // Received fields
	icr_frame_t       resp;              // Reply fields
	logic [15:0]      cmd_w;             // Object 1 command
	logic [15:0]      val_w;             // Object 1 value
	logic             frame_ok;          // Frame passes checks
	logic             exec;              // Frame executes now
	logic             cfg;               // Object 1 executes
	logic             unlocked;          // Allowance open
	logic             self_rst;          // Reset command taken
	logic [15:0]      par_rd;            // Addressed parameter
	logic [APP_W+IDX_W-1:0] par_idx;     // Store index
	// AXI
	logic [`AXI_AW-1:0] awaddr_q;        // Held write address
	logic [31:0]      wdata_q;           // Held write data
	logic [3:0]       wstrb_q;           // Held byte enables
	logic             aw_got_q;          // Address held
	logic             w_got_q;           // Data held
	logic             aw_got_d;          // Next address held
	logic             w_got_d;           // Next data held
	logic             bvalid_d;          // Next response valid
	logic             rvalid_d;          // Next read valid
	logic             wr_fire;           // Write performed
	logic             ar_take;           // Read accepted
	logic [`AXI_AW-1:0] wa;              // Aligned write address
	logic [`AXI_AW-1:0] ra;              // Aligned read address

	assign rst_int = !RST_N || RESET_REQ;

	// ==========================================================
	// Frame decode and reply build
	always_comb begin
		fr = icr_frame_t'(body_q[47:8]);
		cmd_w = {fr.d1, fr.d0};
		val_w = {fr.d3, fr.d2};
		frame_ok = link_en_q && crc8(body_q[47:8]) == body_q[7:0]
			&& fr.seq == seq_q
			&& (fr.obj == `OBJ_STATUS || fr.obj == `OBJ_SYSCFG ||
			fr.obj == `OBJ_GETPAR || fr.obj == `OBJ_SETPAR);
		exec = st_q == ST_EXEC && frame_ok;
		cfg = exec && fr.obj == `OBJ_SYSCFG;
		unlocked = unlock_q != 2'h0;
		self_rst = cfg && cmd_w == `CMD_RESET && val_w == `VAL_OFF && unlocked;
		par_idx = {fr.d0[APP_W-1:0], fr.d1[IDX_W-1:0]};
		par_rd = par_q[par_idx];
		resp = fr;
		resp.seq = tx_seq_q;
		resp.res = 2'h0;
		if (fr.obj == `OBJ_STATUS) begin
			if (fr.d0 == `SEL_STATE) begin
				resp.d0 = STATUS_IN.motor_state_number;
				resp.d1 = STATUS_IN.power_factor_state_number;
				resp.d2 = `FILL_BYTE;
				resp.d3 = `FILL_BYTE;
			end else if (fr.d0 == `SEL_LOAD) begin
				{resp.d1, resp.d0} = STATUS_IN.exe_time;
				{resp.d3, resp.d2} = STATUS_IN.cpu_load;
			end else begin
				// Unknown selector answers zeros
				{resp.d0, resp.d1, resp.d2, resp.d3} = {2{`VAL_OFF}};
			end
		end else if (fr.obj == `OBJ_GETPAR) begin
			{resp.d3, resp.d2} = par_rd;
		end
	end

	// ==========================================================
	// Receive, execute, transmit sequencer
	always_ff @(posedge CLK) begin
		if (rst_int) begin
			st_q <= ST_HUNT;
			cnt_q <= 3'h0;
			body_q <= '0;
			tx_buf_q <= '0;
			tx_seq_q <= 2'h0;
			TX_VALID <= 1'b0;
			TX_BYTE <= 8'h00;
		end else begin
			unique case (st_q)
				ST_HUNT: begin // Wait for opening flag
					if (RX_VALID && RX_BYTE == `FLAG_BYTE) begin
						st_q <= ST_BODY;
						cnt_q <= 3'h0;
					end
				end
				ST_BODY: begin // Six bytes between flags
					if (RX_VALID) begin
						body_q <= {body_q[39:0], RX_BYTE};
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == `BODY_LAST)
							st_q <= ST_TAIL;
					end
				end
				ST_TAIL: begin // Closing flag or drop
					if (RX_VALID)
						st_q <= (RX_BYTE == `FLAG_BYTE) ? ST_EXEC : ST_HUNT;
				end
				ST_EXEC: begin
					if (exec && !self_rst) begin
						st_q <= ST_SEND;
						cnt_q <= 3'h0;
						TX_VALID <= 1'b1;
						TX_BYTE <= `FLAG_BYTE;
						tx_buf_q <= {resp, crc8(resp), `FLAG_BYTE};
						tx_seq_q <= tx_seq_q + 2'h1;
					end else begin
						st_q <= ST_HUNT;
					end
				end
				ST_SEND: begin // Incoming bytes ignored here
					if (TX_READY) begin
						cnt_q <= cnt_q + 3'h1;
						TX_BYTE <= tx_buf_q[55:48];
						tx_buf_q <= {tx_buf_q[47:0], 8'h00};
						if (cnt_q == `TX_LAST) begin
							TX_VALID <= 1'b0;
							st_q <= ST_HUNT;
						end
					end
				end
				default: st_q <= ST_HUNT;
			endcase
		end
	end

	// ==========================================================
	// Self reset pulse, only power reset clears it
	always_ff @(posedge CLK) begin
		if (!RST_N)
			RESET_REQ <= 1'b0;
		else
			RESET_REQ <= self_rst;
	end

	// ==========================================================
	// Boot mode survives self reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			BOOT_MODE <= MODE_APP;
		end else if (cfg && unlocked && cmd_w == `CMD_BOOT) begin
			if (val_w == `BOOT_CFG)
				BOOT_MODE <= MODE_CFG;
			else if (val_w == `BOOT_LDR)
				BOOT_MODE <= MODE_BOOT;
		end
	end

	// ==========================================================
	// Configuration state changed by object 1 and software
	always_ff @(posedge CLK) begin
		if (rst_int) begin
			seq_q <= 2'h0;
			unlock_q <= 2'h0;
			STATIC_WR_EN <= 1'b0;
			COHERENT_EN <= 1'b0;
			COH_APPLY <= 1'b0;
			BAUD_DIV <= `BAUD_DEF;
			err_q <= 3'h0;
			file_arg_q <= 16'h0000;
			file_op_q <= 2'h0;
			file_pend_q <= 1'b0;
			ok_cnt_q <= 16'h0000;
			drop_cnt_q <= 16'h0000;
		end else begin
			COH_APPLY <= cfg && cmd_w == `CMD_COH_SET;
			if (exec) begin
				seq_q <= seq_q + 2'h1;
				ok_cnt_q <= ok_cnt_q + 16'h0001;
			end else if (st_q == ST_EXEC) begin
				drop_cnt_q <= drop_cnt_q + 16'h0001;
			end else if (wr_fire && wa == `REG_SEQ && wstrb_q[0]) begin
				seq_q <= wdata_q[1:0];
			end
			if (cfg) begin
				if (cmd_w == `CMD_UNLOCK) begin
					if (val_w <= `UNLOCK_MAX)
						unlock_q <= val_w[1:0];
				end else if (unlocked) begin
					unlock_q <= unlock_q - 2'h1;
				end
				if (unlocked && cmd_w == `CMD_STATIC) begin
					if (val_w == `VAL_ON)
						STATIC_WR_EN <= 1'b1;
					else if (val_w == `VAL_OFF)
						STATIC_WR_EN <= 1'b0;
				end
				if (cmd_w == `CMD_BAUD)
					BAUD_DIV <= val_w;
				if (cmd_w == `CMD_COH_EN)
					COHERENT_EN <= 1'b1;
				if (cmd_w == `CMD_COH_DIS)
					COHERENT_EN <= 1'b0;
			end
			// Framing errors past the limit restore default baud
			if (RX_FRAME_ERR) begin
				if (err_q == `ERR_LIMIT) begin
					BAUD_DIV <= `BAUD_DEF;
					err_q <= 3'h0;
				end else begin
					err_q <= err_q + 3'h1;
				end
			end else if (exec) begin
				err_q <= 3'h0;
			end
			// File request latch; a new request wins over clear
			if (cfg && (cmd_w == `CMD_FLOAD || cmd_w == `CMD_FSAVE ||
				cmd_w == `CMD_FERASE)) begin
				file_op_q <= cmd_w[1:0];
				file_arg_q <= val_w;
				file_pend_q <= 1'b1;
			end else if (wr_fire && wa == `REG_FILE && wstrb_q[3] &&
				wdata_q[`FILE_PEND]) begin
				file_pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software link enable
	always_ff @(posedge CLK) begin
		if (rst_int)
			link_en_q <= 1'b1;
		else if (wr_fire && wa == `REG_CTRL && wstrb_q[0])
			link_en_q <= wdata_q[0];
	end

	// ==========================================================
	// Parameter store, one word per entry
	for (genvar g = 0; g < PAR_N; g++) begin : g_par
		always_ff @(posedge CLK) begin
			if (!RST_N)
				par_q[g] <= 16'h0000;
			else if (exec && fr.obj == `OBJ_SETPAR && par_idx == g &&
				(fr.d0 != `STATIC_APP || STATIC_WR_EN))
				par_q[g] <= val_w;
		end
	end

	// ==========================================================
	// AXI4-Lite handshake bookkeeping
	always_comb begin
		wa = {awaddr_q[`AXI_AW-1:2], 2'b00};
		ra = {S_AXI_ARADDR[`AXI_AW-1:2], 2'b00};
		wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID;
		aw_got_d = !wr_fire && (aw_got_q || (S_AXI_AWVALID && S_AXI_AWREADY));
		w_got_d = !wr_fire && (w_got_q || (S_AXI_WVALID && S_AXI_WREADY));
		bvalid_d = wr_fire || (S_AXI_BVALID && !S_AXI_BREADY);
		ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
		rvalid_d = ar_take || (S_AXI_RVALID && !S_AXI_RREADY);
	end

	// ==========================================================
	// AXI write channels
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
				awaddr_q <= S_AXI_AWADDR;
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
			S_AXI_AWREADY <= !aw_got_d && !bvalid_d;
			S_AXI_WREADY <= !w_got_d && !bvalid_d;
			S_AXI_BVALID <= bvalid_d;
			if (wr_fire)
				S_AXI_BRESP <= reg_known(wa) ? `RESP_OKAY : `RESP_DECERR;
		end
	end

	// ==========================================================
	// AXI read channels
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !rvalid_d;
			S_AXI_RVALID <= rvalid_d;
			if (ar_take) begin
				S_AXI_RRESP <= reg_known(ra) ? `RESP_OKAY : `RESP_DECERR;
				unique case (ra)
					`REG_CTRL: S_AXI_RDATA <= {31'h0, link_en_q};
					`REG_STAT: S_AXI_RDATA <= {21'h0, err_q, unlock_q,
						COHERENT_EN, STATIC_WR_EN, 1'b0, BOOT_MODE};
					`REG_BAUD: S_AXI_RDATA <= {16'h0000, BAUD_DIV};
					`REG_SEQ:  S_AXI_RDATA <= {28'h0, tx_seq_q, seq_q};
					`REG_FILE: S_AXI_RDATA <= {file_pend_q, 13'h0, file_op_q,
						file_arg_q};
					`REG_CNT:  S_AXI_RDATA <= {drop_cnt_q, ok_cnt_q};
					default:   S_AXI_RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ---- icr_host_model.sv ----
`timescale 1ns/1ps
// ====================
// Link master: frames commands, takes replies
module icr_host_model import icr_pkg::*; (
	input  wire logic  clk,      // Clock
	input  wire logic  slow,     // Stall replies
	input  wire logic  rnd,      // Random stall bit
	output logic       tx_ready, // Takes reply byte
	output logic       rx_valid, // Command byte strobe
	output logic [7:0] rx_byte   // Command byte
);
	logic [1:0] seq_q; // Next sequence number
	initial begin
		{seq_q, rx_valid, rx_byte} = '0;
	end
	// Reply acceptance, free or stalling
	always @(posedge clk) tx_ready <= !slow || rnd;
	// Check byte, MSB first over header and data
	function automatic logic [7:0] crc8(input logic [39:0] m);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// Whole frame; f[0] spoils check, f[1] spoils sequence
	task automatic send(input logic [3:0] o, input logic [31:0] d, input logic [1:0] f);
		logic [39:0] m;
		logic [63:0] b;
		m = {seq_q ^ {f[1], 1'b0}, 2'b00, o, d};
		b = {8'h7E, m, crc8(m) ^ {7'h00, f[0]}, 8'h7E};
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_byte  <= b[i*8 +: 8];
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_byte  <= ~b[i*8 +: 8]; // Idle line never shows stale byte
		end
		if (f == 2'h0)
			seq_q = seq_q + 2'h1;
	endtask
endmodule

// ---- icr_monitor.sv ----
`timescale 1ns/1ps
// ====================
// Link and bus protocol checker
module icr_monitor import icr_pkg::*; (
	input wire logic        CLK,           // Clock
	input wire logic        RST_N,         // Reset, low
	input wire logic        TX_VALID,      // Byte offered
	input wire logic        TX_READY,      // Byte taken
	input wire logic [7:0]  TX_BYTE,       // Reply byte
	input wire logic [15:0] BAUD_DIV,      // Baud word
	input wire logic [2:0]  BOOT_MODE,     // Boot mode
	input wire logic        STATIC_WR_EN,  // Static writes on
	input wire logic        COH_APPLY,     // Apply pulse
	input wire logic        RESET_REQ,     // Self reset
	input wire logic        S_AXI_AWREADY, // Address ready
	input wire logic        S_AXI_WREADY,  // Data ready
	input wire logic        S_AXI_BVALID,  // Response valid
	input wire logic        S_AXI_BREADY,  // Response ready
	input wire logic        S_AXI_RVALID,  // Read valid
	input wire logic        S_AXI_RREADY   // Read ready
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ====================
	// Link side
	property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
	property p_tx_open; $rose(TX_VALID) |-> TX_BYTE == 8'h7E; endproperty
	a_tx_open: assert property (p_tx_open) else $error("reply not opened by flag");
	property p_rst_pulse; RESET_REQ |=> !RESET_REQ; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("self reset too long");
	property p_rst_quiet;
		RESET_REQ |=> (!TX_VALID && !STATIC_WR_EN && BAUD_DIV == 16'h2710) [*4];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("self reset left state");
	property p_coh_pulse; COH_APPLY |=> !COH_APPLY; endproperty
	a_coh_pulse: assert property (p_coh_pulse) else $error("apply pulse too long");
	property p_rel;
		$rose(RST_N) |-> BOOT_MODE == MODE_APP && BAUD_DIV == 16'h2710 && !STATIC_WR_EN;
	endproperty
	a_rel: assert property (p_rel) else $error("bad state after reset");
	// ====================
	// Register bus side
	property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_w_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
	a_w_busy: assert property (p_w_busy) else $error("write taken while answering");
endmodule
bind icr_responder icr_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .TX_BYTE(TX_BYTE), .BAUD_DIV(BAUD_DIV), .BOOT_MODE(BOOT_MODE),
	.STATIC_WR_EN(STATIC_WR_EN), .COH_APPLY(COH_APPLY), .RESET_REQ(RESET_REQ),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ---- icr_tb.sv ----
`timescale 1ns/1ps
// ====================
// Responder bench
module tb import icr_pkg::*; ();
	logic        clk, rst_n, rx_valid, rx_ferr, tx_ready, tx_valid, slow, rnd;
	logic [7:0]  rx_byte, tx_byte;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, vv;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic        arready, rvalid, coh_en, st_en, coh_ap, rst_rq;
	logic [1:0]  bresp, rresp, txs;
	logic [15:0] baud;
	icr_mode_t   boot;
	icr_status_t stat, sv;
	logic [31:0] rs = 32'hC52A8B2A; // Random state
	logic [63:0] exq[$], got;       // Expected replies, bytes seen
	int          fails, samples_checked, nb, napp, nrst;
	icr_responder u_dut (.CLK(clk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
		.RX_FRAME_ERR(rx_ferr), .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
		.STATUS_IN(stat), .BAUD_DIV(baud), .BOOT_MODE(boot), .STATIC_WR_EN(st_en),
		.COHERENT_EN(coh_en), .COH_APPLY(coh_ap), .RESET_REQ(rst_rq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	icr_host_model u_host (.clk(clk), .slow(slow), .rnd(rnd), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_byte(rx_byte));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	always @(posedge clk) rnd <= xs() > 32'h80000000;
	task automatic chk(input string n, input logic [63:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Reply collector: eight bytes make one frame
	always @(posedge clk) if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
		got = {got[55:0], tx_byte};
		nb++;
		if (nb == 8) begin
			nb = 0;
			if (exq.size() == 0) chk("unexpected reply", 64'h0, got);
			else chk("reply frame", exq.pop_front(), got);
		end
	end
	// Pulse counters
	always @(posedge clk) begin
		if (coh_ap === 1'b1) napp++;
		if (rst_rq === 1'b1) nrst++;
	end
	// One command, expected reply noted first, bounded wait
	task automatic frm(input logic [3:0] o, input logic [31:0] d, e, input logic [1:0] f,
			input logic r);
		logic [39:0] m;
		if (r) begin
			m = {txs, 2'b00, o, e};
			exq.push_back({8'h7E, m, u_host.crc8(m), 8'h7E});
			txs++;
		end
		u_host.send(o, d, f);
		for (int i = 0; i < 500 && exq.size() != 0; i++) @(posedge clk);
		if (exq.size() != 0) begin
			chk("reply wait", 64'h0, 64'h1);
			final_report();
		end
		repeat (20) @(posedge clk);
	endtask
	function automatic logic [31:0] w(input logic [15:0] c, v);
		return {c[7:0], c[15:8], v[7:0], v[15:8]};
	endfunction
	task automatic c1(input logic [15:0] c, v);
		frm(4'h1, w(c, v), w(c, v), 2'h0, 1'b1);
	endtask
	task automatic par(input logic [15:0] ai, wv, rv);
		frm(4'h7, {ai, wv}, {ai, wv}, 2'h0, 1'b1);
		frm(4'h6, {ai, 16'h0}, {ai, rv}, 2'h0, 1'b1);
	endtask
	task automatic fe(input int n);
		repeat (n) begin
			@(posedge clk);
			rx_ferr <= 1'b1;
			@(posedge clk);
			rx_ferr <= 1'b0;
		end
		repeat (2) @(posedge clk);
	endtask
	task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] r);
		@(posedge clk);
		{awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
		for (int i = 0; i < 50 && bvalid !== 1'b1; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("write resp", {1'b1, r}, {bvalid, bresp});
		if (bvalid !== 1'b1) final_report();
	endtask
	task automatic axr(input logic [5:0] a, input logic [33:0] e);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (int i = 0; i < 50 && rvalid !== 1'b1; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk("read", {1'b1, e}, {rvalid, rresp, rdata});
		if (rvalid !== 1'b1) final_report();
	endtask
	// ====================
	// Main sequence
	initial begin
		{rst_n, rx_ferr, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
		{stat, awaddr, araddr, wdata, wstrb, txs} = '0;
		repeat (10) @(posedge clk);
		sv = {xs(), 16'(xs())};
		rst_n <= 1'b1;
		stat <= sv;
		frm(4'h0, 32'h0, {sv.motor_state_number, sv.power_factor_state_number, 16'hFFFF},
			2'h0, 1'b1);
		frm(4'h0, 32'h01000000, {sv.exe_time[7:0], sv.exe_time[15:8], sv.cpu_load[7:0],
			sv.cpu_load[15:8]}, 2'h0, 1'b1);
		frm(4'h0, 32'h02000000, 32'h0, 2'h0, 1'b1);
		slow <= 1'b1;
		frm(4'h0, 32'h0, 32'h0, 2'h1, 1'b0);
		frm(4'h0, 32'h0, 32'h0, 2'h2, 1'b0);
		frm(4'h3, 32'h0, 32'h0, 2'h0, 1'b0);
		axw(6'h0C, 32'h0, 4'h1, 2'h0);
		u_host.seq_q = 2'h0;
		vv = xs();
		par(16'h0105, vv[15:0], vv[15:0]);
		c1(16'h0002, 16'h0001);
		chk("static locked", 0, st_en);
		c1(16'h0000, 16'h0001);
		c1(16'h0002, 16'h0001);
		chk("static on", 1, st_en);
		par(16'h0002, vv[31:16], vv[31:16]);
		c1(16'h0000, 16'h0001);
		c1(16'h0002, 16'h0000);
		chk("static off", 0, st_en);
		par(16'h0002, ~vv[31:16], vv[31:16]);
		c1(16'h0000, 16'h0002);
		c1(16'h00BD, 16'h32CD);
		chk("boot cfg", MODE_CFG, boot);
		c1(16'h0002, 16'h0001);
		chk("static second", 1, st_en);
		c1(16'h00BD, 16'hA25D);
		chk("boot spent", MODE_CFG, boot);
		c1(16'h0000, 16'h0001);
		c1(16'h00BD, 16'hA25D);
		chk("boot loader", MODE_BOOT, boot);
		c1(16'h0000, 16'h0001);
		c1(16'h0000, 16'h0000);
		c1(16'h0002, 16'h0000);
		chk("static relocked", 1, st_en);
		c1(16'h0100, vv[15:0]);
		chk("baud set", vv[15:0], baud);
		fe(3);
		chk("baud kept", vv[15:0], baud);
		fe(1);
		chk("baud default", 16'h2710, baud);
		c1(16'h0200, 16'h0000);
		chk("coherent on", 1, coh_en);
		c1(16'h0202, 16'h0000);
		chk("apply pulses", 1, napp);
		c1(16'h0201, 16'h0000);
		chk("coherent off", 0, coh_en);
		c1(16'h0300, 16'h0005);
		c1(16'h0302, 16'h0006);
		c1(16'h0301, 16'h0103);
		axr(6'h10, {2'h0, 32'h80010103});
		axw(6'h10, 32'h80000000, 4'h8, 2'h0);
		axr(6'h10, {2'h0, 32'h00010103});
		axr(6'h3C, {2'h3, 32'h0});
		axw(6'h38, vv, 4'hF, 2'h3);
		c1(16'h0000, 16'h0001);
		frm(4'h1, w(16'h0001, 16'h0000), 32'h0, 2'h0, 1'b0);
		u_host.seq_q = 2'h0;
		chk("self resets", 1, nrst);
		chk("static after reset", 0, st_en);
		axr(6'h04, {2'h0, 32'h00000004});
		axr(6'h08, {2'h0, 32'h00002710});
		axw(6'h00, 32'h0, 4'h1, 2'h0);
		frm(4'h0, 32'h0, 32'h0, 2'h0, 1'b0);
		axr(6'h14, {2'h0, 32'h00010000});
		final_report();
	end
endmodule
